// ---- pic_bus_target.sv ----
// Serial target model: one address, takes writes, answers a read with one byte.
// Assumes open-drain lines with pull-ups resolved by the bench.
`timescale 1ns/1ps
module pic_bus_target #(
  parameter logic [6:0] ADDR = 7'h50,
  parameter logic [7:0] TXB = 8'hC5
) (
  input wire logic scl,
  input wire logic sda,
  output logic sda_oe,
  output logic ack_seen,
  output logic [7:0] rx_byte
);
  logic act = 1'b0;
  logic adr = 1'b0;
  logic [7:0] sh = 8'h00;
  // Quiet outputs at start
  initial begin
    sda_oe = 1'b0;
    ack_seen = 1'b0;
    rx_byte = 8'h00;
  end
  // Start or repeated start opens a frame
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      disable body;
      sda_oe = 1'b0;
      adr = 1'b0;
      act = 1'b1;
    end
  end
  // Stop closes the frame
  always @(posedge sda) begin
    if (scl === 1'b1) begin
      disable body;
      sda_oe = 1'b0;
      act = 1'b0;
    end
  end
  // Byte engine, data moved 20 ns after clock falls
  initial forever begin : body
    wait (act);
    repeat (8) @(posedge scl) sh = {sh[6:0], sda};
    if (adr) rx_byte = sh;
    if (adr || sh[7:1] == ADDR) begin
      @(negedge scl) #20 sda_oe = 1'b1;
      if (!adr && sh[0]) begin
        for (int i = 7; i >= 0; i--) @(negedge scl) #20 sda_oe = !TXB[i];
        @(negedge scl) #20 sda_oe = 1'b0;
        @(posedge scl) ack_seen = sda;
        wait (!act);
      end else begin
        adr = 1'b1;
        @(negedge scl) #20 sda_oe = 1'b0;
      end
    end else begin
      wait (!act);
    end
  end
endmodule

// ---- pic_ctrl.sv ----
// Byte controller: parallel register port on one side, open-drain serial bus on the other.
// Assumes asynchronous host strobes and bus lines; all are synchronised here.
`timescale 1ns/1ps
module pic_ctrl (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [1:0] bus_addr,
  input wire logic bus_ce_n,
  input wire logic bus_rd_n,
  input wire logic bus_wr_n,
  input wire logic [7:0] bus_d_i,
  output logic [7:0] bus_d_o,
  output logic bus_d_oe,
  output logic int_n,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  // Complete controller state
  typedef struct packed {
    logic scl_s1, scl_s2, scl_s3;
    logic sda_s1, sda_s2, sda_s3;
    logic ce_s1, ce_s2, rd_s1, rd_s2, rd_s3, wr_s1, wr_s2, wr_s3;
    logic [1:0] a_s1, a_s2;
    logic [7:0] d_s1, d_s2;
    logic wsel, rsel;
    logic [1:0] wa;
    logic [7:0] wd;
    logic [7:0] ctl, dat, adr;
    logic [4:0] code;
    pic_pkg::pic_gen_t gen;
    logic [11:0] tmr;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic master, tx, addr_ph, addressed, lost, xfer, hold, busy;
    logic rstart, ackr, ackd, mscl, push, pop, seen;
    logic [7:0] d_o;
    logic d_oe, int_n, scl_oe, sda_oe, line_o;
  } pic_state_t;
  // Reset image: idle-high strobes and lines, idle code
  localparam pic_state_t ST_RST = '{
    scl_s1: 1'b1, scl_s2: 1'b1, scl_s3: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1, sda_s3: 1'b1,
    ce_s1: 1'b1, ce_s2: 1'b1, rd_s1: 1'b1, rd_s2: 1'b1, rd_s3: 1'b1,
    wr_s1: 1'b1, wr_s2: 1'b1, wr_s3: 1'b1, int_n: 1'b1,
    code: pic_pkg::SC_IDLE[7:3], gen: pic_pkg::G_IDLE, default: '0};
  pic_state_t q, n;
  logic [1:0] rst_q; // Reset release synchroniser
  logic rst_n;
  logic rise, fall, st_det, sp_det, en, tmr0, match, go, start_byte;
  logic [11:0] half;
  logic fifo_in_ready, fifo_out_valid;
  logic [7:0] fifo_out_data;

  // Loads a status code and raises the pending flag
  function automatic pic_state_t raise_event(input pic_state_t s, input logic [7:0] c);
    pic_state_t r;
    r = s;
    r.code = c[7:3];
    r.ctl[pic_pkg::CTL_INT] = 1'b1;
    r.hold = 1'b1;
    return r;
  endfunction

  // Reset release through two flops
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // Received bytes wait here for the host
  pic_fifo #(
    .WIDTH(pic_pkg::FIFO_WIDTH),
    .DEPTH(pic_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(q.push),
    .in_ready(fifo_in_ready),
    .in_data(q.sh),
    .out_valid(fifo_out_valid),
    .out_ready(q.pop),
    .out_data(fifo_out_data)
  );

  // Next-state logic
  always_comb begin
    n = q;
    // Two-flop synchronisers plus edge history
    n.scl_s1 = scl_i;
    n.scl_s2 = q.scl_s1;
    n.scl_s3 = q.scl_s2;
    n.sda_s1 = sda_i;
    n.sda_s2 = q.sda_s1;
    n.sda_s3 = q.sda_s2;
    n.ce_s1 = bus_ce_n;
    n.ce_s2 = q.ce_s1;
    n.rd_s1 = bus_rd_n;
    n.rd_s2 = q.rd_s1;
    n.rd_s3 = q.rd_s2;
    n.wr_s1 = bus_wr_n;
    n.wr_s2 = q.wr_s1;
    n.wr_s3 = q.wr_s2;
    n.a_s1 = bus_addr;
    n.a_s2 = q.a_s1;
    n.d_s1 = bus_d_i;
    n.d_s2 = q.d_s1;
    n.push = 1'b0;
    n.pop = 1'b0;
    n.line_o = 1'b0;
    rise = q.scl_s2 & ~q.scl_s3;
    fall = ~q.scl_s2 & q.scl_s3;
    st_det = q.scl_s2 & q.scl_s3 & q.sda_s3 & ~q.sda_s2;
    sp_det = q.scl_s2 & q.scl_s3 & ~q.sda_s3 & q.sda_s2;
    en = q.ctl[pic_pkg::CTL_BUS_EN];
    half = pic_pkg::half_period(q.ctl[pic_pkg::CTL_RATE_HI:pic_pkg::CTL_RATE_LO]);
    tmr0 = (q.tmr == 12'h000);
    // Upper seven bits, write direction only
    match = (q.sh[7:1] == q.adr[7:1]) & q.ctl[pic_pkg::CTL_ACK_EN] & ~q.sh[0];
    go = q.hold & ~q.ctl[pic_pkg::CTL_INT] & fifo_in_ready;
    start_byte = 1'b0;
    if (!tmr0) begin
      n.tmr = q.tmr - 12'h001;
    end
    // Bus monitored even when not answering
    if (st_det) begin
      n.busy = 1'b1;
      // Foreign start: listen for an address
      if (!q.master && !q.ctl[pic_pkg::CTL_INT]) begin
        n.xfer = 1'b1;
        n.cnt = 4'h0;
        n.addr_ph = 1'b1;
        n.tx = 1'b0;
        n.addressed = 1'b0;
        n.hold = 1'b0;
        // Clock fall that ends the start is no bit
        n.seen = 1'b0;
      end
    end
    if (sp_det) begin
      n.busy = 1'b0;
      n.xfer = 1'b0;
      n.addressed = 1'b0;
      n.ctl[pic_pkg::CTL_HALT] = 1'b0;
      if (!q.ctl[pic_pkg::CTL_INT]) begin
        n.code = pic_pkg::SC_IDLE[7:3];
        n.hold = 1'b0;
      end
    end
    // Capture write address and data while strobed
    if (!q.wr_s2 && !q.ce_s2) begin
      n.wsel = 1'b1;
      n.wa = q.a_s2;
      n.wd = q.d_s2;
    end
    // Write takes effect at strobe release
    if (q.wr_s2 && !q.wr_s3 && q.wsel) begin
      n.wsel = 1'b0;
      case (q.wa)
        pic_pkg::REG_DATA: n.dat = q.wd;
        pic_pkg::REG_ADDR: n.adr = q.wd;
        pic_pkg::REG_CTL: begin
          n.ctl = q.wd;
          // Any control write clears the flag
          n.ctl[pic_pkg::CTL_INT] = 1'b0;
        end
        default: ;
      endcase
    end
    // Read data and drive enable
    n.d_oe = ~q.rd_s2 & ~q.ce_s2;
    case (q.a_s2)
      pic_pkg::REG_CODE: n.d_o = {q.code, 3'h0};
      pic_pkg::REG_DATA: n.d_o = fifo_out_valid ? fifo_out_data : q.dat;
      pic_pkg::REG_ADDR: n.d_o = q.adr;
      default: n.d_o = q.ctl;
    endcase
    if (n.d_oe && q.a_s2 == pic_pkg::REG_DATA) begin
      n.rsel = 1'b1;
    end
    // Data read pops one buffered byte at release
    if (q.rd_s2 && !q.rd_s3 && q.rsel) begin
      n.rsel = 1'b0;
      n.pop = fifo_out_valid;
    end
    // Master line sequencer
    unique case (q.gen)
      pic_pkg::G_IDLE: begin
        // Start request waits for free bus
        if (en && q.ctl[pic_pkg::CTL_BEGIN] && !q.busy && !q.hold && !q.addressed) begin
          n.gen = pic_pkg::G_BUF;
          n.tmr = half;
        end
      end
      pic_pkg::G_BUF: begin
        // Start only after bus stays free
        if (q.busy) begin
          n.gen = pic_pkg::G_IDLE;
        end else if (tmr0) begin
          n.master = 1'b1;
          n.sda_oe = 1'b1;
          n.rstart = 1'b0;
          n.gen = pic_pkg::G_ST_A;
          n.tmr = half;
        end
      end
      pic_pkg::G_ST_A: begin
        if (tmr0) begin
          n.mscl = 1'b1;
          n.gen = pic_pkg::G_ST_B;
          n.tmr = half;
        end
      end
      pic_pkg::G_ST_B: begin
        if (tmr0) begin
          n.xfer = 1'b0;
          n = raise_event(n, q.rstart ? pic_pkg::SC_RSTART : pic_pkg::SC_START);
          n.gen = pic_pkg::G_HOLD;
        end
      end
      pic_pkg::G_LOW: begin
        // Clock stays low at a byte end
        if (tmr0) begin
          if (q.hold) begin
            n.gen = pic_pkg::G_HOLD;
          end else begin
            n.mscl = 1'b0;
            n.gen = pic_pkg::G_HIGH;
            n.tmr = half;
          end
        end
      end
      pic_pkg::G_HIGH: begin
        // High time counts only once line is high
        if (!q.scl_s2) begin
          n.tmr = half;
        end else if (tmr0) begin
          n.mscl = 1'b1;
          n.gen = pic_pkg::G_LOW;
          n.tmr = half;
        end
      end
      pic_pkg::G_HOLD: ;
      pic_pkg::G_RS_A: begin
        if (tmr0) begin
          n.mscl = 1'b0;
          n.gen = pic_pkg::G_RS_B;
          n.tmr = half;
        end
      end
      pic_pkg::G_RS_B: begin
        if (!q.scl_s2) begin
          n.tmr = half;
        end else if (tmr0) begin
          n.sda_oe = 1'b1;
          n.rstart = 1'b1;
          n.gen = pic_pkg::G_ST_A;
          n.tmr = half;
        end
      end
      pic_pkg::G_SP_A: begin
        if (tmr0) begin
          n.mscl = 1'b0;
          n.gen = pic_pkg::G_SP_B;
          n.tmr = half;
        end
      end
      pic_pkg::G_SP_B: begin
        if (!q.scl_s2) begin
          n.tmr = half;
        end else if (tmr0) begin
          n.sda_oe = 1'b0;
          n.master = 1'b0;
          n.gen = pic_pkg::G_IDLE;
        end
      end
      default: n.gen = pic_pkg::G_IDLE;
    endcase
    // Resume after the host cleared the flag
    if (go) begin
      n.hold = 1'b0;
      if (q.master) begin
        if (q.code == pic_pkg::SC_START[7:3] || q.code == pic_pkg::SC_RSTART[7:3]) begin
          n.tx = 1'b1;
          n.addr_ph = 1'b1;
          start_byte = 1'b1;
        end else if (q.ctl[pic_pkg::CTL_HALT]) begin
          // Stop, then start if also begun
          n.sda_oe = 1'b1;
          n.gen = pic_pkg::G_SP_A;
          n.tmr = half;
        end else if (q.ctl[pic_pkg::CTL_BEGIN]) begin
          n.sda_oe = 1'b0;
          n.gen = pic_pkg::G_RS_A;
          n.tmr = half;
        end else begin
          n.addr_ph = 1'b0;
          start_byte = 1'b1;
        end
      end else if (q.addressed && q.code != pic_pkg::SC_SD_NACK[7:3]) begin
        n.addr_ph = 1'b0;
        n.cnt = 4'h0;
        n.xfer = 1'b1;
        n.sda_oe = 1'b0;
      end else begin
        // Release; idle sequencer restarts if begun
        n.addressed = 1'b0;
        n.xfer = 1'b0;
      end
    end
    if (start_byte) begin
      n.sh = q.dat;
      n.sda_oe = n.tx & ~q.dat[7];
      n.cnt = 4'h0;
      n.xfer = 1'b1;
      n.gen = pic_pkg::G_LOW;
      n.tmr = half;
    end
    // Bit engine, paced by clock edges on the line
    if (en && q.xfer && !q.hold) begin
      if (rise) begin
        n.seen = 1'b1;
        if (q.cnt == pic_pkg::ACK_SLOT) begin
          n.ackr = q.sda_s2;
        end else begin
          n.sh = {q.sh[6:0], q.sda_s2};
          if (q.master && q.tx && !q.sda_oe && !q.sda_s2) begin
            n.master = 1'b0;
            n.lost = 1'b1;
            n.tx = 1'b0;
            n.mscl = 1'b0;
            n.gen = pic_pkg::G_IDLE;
          end
        end
      end
      // Falls count only after a bit's rise
      if (fall && q.seen) begin
        if (q.cnt < pic_pkg::LAST_BIT) begin
          n.cnt = q.cnt + 4'h1;
          n.sda_oe = q.master & q.tx & ~q.sh[7];
        end else if (q.cnt == pic_pkg::LAST_BIT) begin
          n.cnt = pic_pkg::ACK_SLOT;
          if (q.master && q.tx) begin
            n.sda_oe = 1'b0;
          end else if (q.addr_ph && !q.master) begin
            // Answer own address only when enabled
            n.sda_oe = match;
            n.addressed = match;
          end else if (q.master || q.addressed) begin
            n.sda_oe = q.ctl[pic_pkg::CTL_ACK_EN];
            n.ackd = q.ctl[pic_pkg::CTL_ACK_EN];
          end else begin
            n.sda_oe = 1'b0;
          end
        end else begin
          n.sda_oe = 1'b0;
          n.cnt = 4'h0;
          n.addr_ph = 1'b0;
          if (q.master && q.addr_ph) begin
            n.tx = ~q.sh[0];
            if (q.sh[0]) begin
              n = raise_event(n, q.ackr ? pic_pkg::SC_AR_NACK : pic_pkg::SC_AR_ACK);
            end else begin
              n = raise_event(n, q.ackr ? pic_pkg::SC_AW_NACK : pic_pkg::SC_AW_ACK);
            end
          end else if (q.master && q.tx) begin
            n = raise_event(n, q.ackr ? pic_pkg::SC_TD_NACK : pic_pkg::SC_TD_ACK);
          end else if (q.master) begin
            n.push = 1'b1;
            n = raise_event(n, q.ackd ? pic_pkg::SC_RD_ACK : pic_pkg::SC_RD_NACK);
          end else if (q.addr_ph && q.addressed) begin
            n.lost = 1'b0;
            n = raise_event(n, q.lost ? pic_pkg::SC_SW_ARB : pic_pkg::SC_SW_ACK);
          end else if (q.lost) begin
            n.lost = 1'b0;
            n = raise_event(n, pic_pkg::SC_ARB_LOST);
          end else if (q.addressed) begin
            n.push = 1'b1;
            n = raise_event(n, q.ackd ? pic_pkg::SC_SD_ACK : pic_pkg::SC_SD_NACK);
          end else begin
            n.xfer = 1'b0;
          end
        end
      end
    end
    // Disabled: lines released, slave unaddressed
    if (!en) begin
      n.master = 1'b0;
      n.gen = pic_pkg::G_IDLE;
      n.mscl = 1'b0;
      n.sda_oe = 1'b0;
      n.xfer = 1'b0;
      n.addressed = 1'b0;
      n.hold = 1'b0;
      n.busy = 1'b0;
      n.lost = 1'b0;
      n.code = pic_pkg::SC_IDLE[7:3];
    end
    n.scl_oe = n.mscl | (n.hold & n.addressed & ~n.master);
    n.int_n = ~(n.ctl[pic_pkg::CTL_INT] & n.ctl[pic_pkg::CTL_BUS_EN]);
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= ST_RST;
    end else begin
      q <= n;
    end
  end

  // Outputs straight from state flops
  assign bus_d_o = q.d_o;
  assign bus_d_oe = q.d_oe;
  assign int_n = q.int_n;
  assign scl_o = q.line_o;
  assign scl_oe = q.scl_oe;
  assign sda_o = q.line_o;
  assign sda_oe = q.sda_oe;
endmodule

// ---- pic_ctrl_sva.sv ----
// Port checker for the byte controller.
// Assumes it is bound onto pic_ctrl and sees only its ports.
`timescale 1ns/1ps
module pic_ctrl_sva (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [1:0] bus_addr,
  input wire logic bus_ce_n,
  input wire logic bus_rd_n,
  input wire logic bus_wr_n,
  input wire logic [7:0] bus_d_i,
  input wire logic [7:0] bus_d_o,
  input wire logic bus_d_oe,
  input wire logic int_n,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe
);
  // One domain, reset disables all
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // Status shown on a settled read
  chk_code_low: assert property (bus_d_oe && bus_addr == pic_pkg::REG_CODE
    && $past(bus_addr, 4) == pic_pkg::REG_CODE |-> bus_d_o[2:0] == 3'h0)
    else $error("status low bits not zero");
  // Pending flag never pairs with idle code
  chk_pend_code: assert property (bus_d_oe && bus_addr == pic_pkg::REG_CODE
    && $past(bus_addr, 4) == pic_pkg::REG_CODE && !int_n && $past(int_n, 4) == 1'b0
    |-> bus_d_o != pic_pkg::SC_IDLE)
    else $error("idle code with interrupt pending");
  // Held clock low stays low while pending
  chk_scl_hold: assert property ($past(int_n) == 1'b0 && !int_n && $past(scl_oe)
    |-> scl_oe)
    else $error("clock released while pending");
  // Data line frozen while pending
  chk_sda_hold: assert property ($past(int_n) == 1'b0 && !int_n |-> $stable(sda_oe))
    else $error("data line moved while pending");
  // Control write drops the interrupt
  chk_int_clear: assert property ($rose(bus_wr_n) && $past(bus_ce_n) == 1'b0
    && bus_addr == pic_pkg::REG_CTL |-> ##[1:10] int_n)
    else $error("interrupt not cleared by control write");
  // Stop brings no interrupt
  chk_stop_quiet: assert property ($fell(sda_oe) && scl_i && !scl_oe |-> int_n [*8])
    else $error("interrupt raised on stop");
  // Start made with clock released
  chk_start_form: assert property ($rose(sda_oe) && scl_i |-> !scl_oe [*8])
    else $error("start without clock high");
  // Read answer and release
  chk_rd_answer: assert property (!bus_ce_n && !bus_rd_n |-> ##[0:4] bus_d_oe)
    else $error("read not answered");
  chk_oe_drop: assert property (bus_rd_n [*5] |-> !bus_d_oe)
    else $error("data bus driven without read");
  // Main scenarios reached
  cov_pend: cover property (!int_n ##1 int_n);
  cov_stop: cover property ($fell(sda_oe) && scl_i && !scl_oe);
  cov_start: cover property ($rose(sda_oe) && scl_i);
endmodule

// ---- pic_ctrl_tb_top.sv ----
// Self-checking bench for pic_ctrl against one serial target.
// Assumes package, design, checker and target model compiled first.
`timescale 1ns/1ps
module pic_ctrl_tb_top;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [1:0] bus_addr = 2'h0;
  logic bus_ce_n = 1'b1;
  logic bus_rd_n = 1'b1;
  logic bus_wr_n = 1'b1;
  logic [7:0] bus_d_i = 8'h00;
  logic [7:0] bus_d_o, rx_byte;
  logic [7:0] v = 8'h00;
  logic bus_d_oe, int_n, scl_o, scl_oe, sda_o, sda_oe, m_oe, m_ack, scl, sda, b_ack;
  // Bench acting as a foreign master: pull-low enables
  logic b_scl_oe = 1'b0;
  logic b_sda_oe = 1'b0;
  int err_count = 0;
  int n_tests = 0;
  // Pulled-up open-drain lines
  assign scl = !(scl_oe || b_scl_oe);
  assign sda = !(sda_oe || m_oe || b_sda_oe);
  always #2 clk_sys = !clk_sys;
  pic_ctrl dut (.clk_sys(clk_sys), .arst_n(arst_n), .bus_addr(bus_addr),
    .bus_ce_n(bus_ce_n), .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n), .bus_d_i(bus_d_i),
    .bus_d_o(bus_d_o), .bus_d_oe(bus_d_oe), .int_n(int_n), .scl_i(scl), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
  pic_bus_target #(.ADDR(7'h50), .TXB(8'hC5)) tgt (.scl(scl), .sda(sda), .sda_oe(m_oe),
    .ack_seen(m_ack), .rx_byte(rx_byte));
  // Compare and count
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One register access, read data kept in v
  task automatic acc(input logic [1:0] a, input logic wr, input logic [7:0] d);
    bus_addr = a;
    bus_d_i = d;
    bus_ce_n = 1'b0;
    bus_rd_n = wr;
    bus_wr_n = !wr;
    repeat (6) @(negedge clk_sys);
    v = bus_d_o;
    bus_ce_n = 1'b1;
    bus_rd_n = 1'b1;
    bus_wr_n = 1'b1;
    repeat (8) @(negedge clk_sys);
  endtask
  // Load data, write control, await interrupt, check code
  task automatic step(input logic [7:0] d, input logic [7:0] c, input logic [7:0] code);
    acc(pic_pkg::REG_DATA, 1'b1, d);
    acc(pic_pkg::REG_CTL, 1'b1, c);
    for (int i = 0; i < 20000 && int_n !== 1'b0; i++) @(negedge clk_sys);
    acc(pic_pkg::REG_CODE, 1'b0, 8'h00);
    chk("code", v, code);
  endtask
  // Stop request, poll until hardware clears it
  task automatic halt();
    acc(pic_pkg::REG_CTL, 1'b1, 8'h50);
    v = 8'hFF;
    for (int i = 0; i < 400 && v[4] !== 1'b0; i++) acc(pic_pkg::REG_CTL, 1'b0, 8'h00);
    chk("ctrl", v, 8'h40);
    acc(pic_pkg::REG_CODE, 1'b0, 8'h00);
    chk("idle", v, pic_pkg::SC_IDLE);
    chk("int_n", {7'h0, int_n}, 8'h01);
  endtask
  // Foreign master bit, 160 ns period, stretch honoured
  task automatic mbit(input logic b, output logic s);
    b_sda_oe = !b;
    repeat (10) @(negedge clk_sys);
    b_scl_oe = 1'b0;
    for (int i = 0; i < 5000 && scl !== 1'b1; i++) @(negedge clk_sys);
    repeat (10) @(negedge clk_sys);
    s = sda;
    repeat (10) @(negedge clk_sys);
    b_scl_oe = 1'b1;
    repeat (10) @(negedge clk_sys);
  endtask
  // Foreign start plus address byte, ack level kept in b_ack
  task automatic mframe(input logic [7:0] a);
    logic s;
    b_sda_oe = 1'b1;
    repeat (20) @(negedge clk_sys);
    b_scl_oe = 1'b1;
    repeat (10) @(negedge clk_sys);
    for (int i = 7; i >= 0; i--) mbit(a[i], s);
    mbit(1'b1, b_ack);
  endtask
  // Foreign stop once the clock line is free
  task automatic mstop();
    b_sda_oe = 1'b1;
    repeat (10) @(negedge clk_sys);
    b_scl_oe = 1'b0;
    for (int i = 0; i < 5000 && scl !== 1'b1; i++) @(negedge clk_sys);
    repeat (20) @(negedge clk_sys);
    b_sda_oe = 1'b0;
    repeat (20) @(negedge clk_sys);
  endtask
  // Verdict
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (20) @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    acc(pic_pkg::REG_CODE, 1'b1, 8'h00);
    for (int r = 0; r < 4; r++) begin
      acc(2'(r), 1'b0, 8'h00);
      chk("reset", v, r == 0 ? pic_pkg::SC_IDLE : 8'h00);
    end
    acc(pic_pkg::REG_ADDR, 1'b1, 8'h24);
    acc(pic_pkg::REG_ADDR, 1'b0, 8'h00);
    chk("own", v, 8'h24);
    acc(pic_pkg::REG_CTL, 1'b1, 8'h40);
    step(8'h00, 8'h60, pic_pkg::SC_START);
    step(8'hA0, 8'h40, pic_pkg::SC_AW_ACK);
    step(8'h3C, 8'h40, pic_pkg::SC_TD_ACK);
    chk("rx", rx_byte, 8'h3C);
    step(8'h00, 8'h60, pic_pkg::SC_RSTART);
    step(8'hA1, 8'h40, pic_pkg::SC_AR_ACK);
    step(8'h00, 8'h40, pic_pkg::SC_RD_NACK);
    acc(pic_pkg::REG_DATA, 1'b0, 8'h00);
    chk("rdata", v, 8'hC5);
    chk("ack", {7'h0, m_ack}, 8'h01);
    halt();
    step(8'h00, 8'h60, pic_pkg::SC_START);
    step(8'hB0, 8'h40, pic_pkg::SC_AW_NACK);
    halt();
    // Own address ignored while ack enable is low
    mframe(8'h24);
    chk("nack", {7'h0, b_ack}, 8'h01);
    chk("quiet", {7'h0, int_n}, 8'h01);
    mstop();
    // Ack enable back on: addressed as slave receiver
    acc(pic_pkg::REG_CTL, 1'b1, 8'hC0);
    mframe(8'h24);
    for (int i = 0; i < 100 && int_n !== 1'b0; i++) @(negedge clk_sys);
    chk("sack", {7'h0, b_ack}, 8'h00);
    chk("stretch", {5'h0, scl_oe, scl_o, sda_o}, 8'h04);
    acc(pic_pkg::REG_CODE, 1'b0, 8'h00);
    chk("slave", v, pic_pkg::SC_SW_ACK);
    acc(pic_pkg::REG_CTL, 1'b1, 8'hC0);
    mstop();
    acc(pic_pkg::REG_CODE, 1'b0, 8'h00);
    chk("sidle", v, pic_pkg::SC_IDLE);
    close_out();
  end
  // Watchdog
  initial begin
    repeat (62000) @(posedge clk_sys);
    err_count++;
    close_out();
  end
endmodule
bind pic_ctrl pic_ctrl_sva u_chk (.clk_sys(clk_sys), .arst_n(arst_n), .bus_addr(bus_addr),
  .bus_ce_n(bus_ce_n), .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n), .bus_d_i(bus_d_i),
  .bus_d_o(bus_d_o), .bus_d_oe(bus_d_oe), .int_n(int_n), .scl_i(scl_i), .scl_o(scl_o),
  .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));

// ---- pic_fifo.sv ----
// Receive byte buffer with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset copy; depth a power of two.
`timescale 1ns/1ps
module pic_fifo #(
  parameter int WIDTH = pic_pkg::FIFO_WIDTH,
  parameter int DEPTH = pic_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // Whole buffer state
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } pic_fifo_state_t;
  pic_fifo_state_t q, n;
  logic wr, rd;
  // Honest flags from the fill count
  assign in_ready = (q.cnt != (AW + 1)'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign out_data = q.mem[q.rp];
  // Next state
  always_comb begin
    n = q;
    wr = in_valid & in_ready;
    rd = out_valid & out_ready;
    if (wr) begin
      n.mem[q.wp] = in_data;
      n.wp = q.wp + 1'b1;
    end
    if (rd) begin
      n.rp = q.rp + 1'b1;
    end
    // Count moves only when one side acts alone
    if (wr && !rd) begin
      n.cnt = q.cnt + 1'b1;
    end else if (rd && !wr) begin
      n.cnt = q.cnt - 1'b1;
    end
  end
  // State register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
endmodule

// ---- pic_pkg.sv ----
// Constants, status codes and sequencer states for the byte-wide bus controller.
// Assumes a 250 MHz system clock; all users write pic_pkg::name.
package pic_pkg;
  // System clock rate in kHz
  localparam int SYS_CLK_KHZ = 250000;
  // Serial clock rates selectable by the rate bits, kHz
  localparam int RATE_KHZ [8] = '{330, 288, 217, 146, 88, 59, 44, 36};
  // Receive buffer shape
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;
  // Register indices on the parallel port
  localparam logic [1:0] REG_CODE = 2'h0;
  localparam logic [1:0] REG_DATA = 2'h1;
  localparam logic [1:0] REG_ADDR = 2'h2;
  localparam logic [1:0] REG_CTL = 2'h3;
  // Control register bit positions
  localparam int CTL_ACK_EN = 7;
  localparam int CTL_BUS_EN = 6;
  localparam int CTL_BEGIN = 5;
  localparam int CTL_HALT = 4;
  localparam int CTL_INT = 3;
  localparam int CTL_RATE_HI = 2;
  localparam int CTL_RATE_LO = 0;
  // Bit slot counter values
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  // Status codes
  localparam logic [7:0] SC_IDLE = 8'hF8;
  localparam logic [7:0] SC_START = 8'h08;
  localparam logic [7:0] SC_RSTART = 8'h10;
  localparam logic [7:0] SC_AW_ACK = 8'h18;
  localparam logic [7:0] SC_AW_NACK = 8'h20;
  localparam logic [7:0] SC_TD_ACK = 8'h28;
  localparam logic [7:0] SC_TD_NACK = 8'h30;
  localparam logic [7:0] SC_ARB_LOST = 8'h38;
  localparam logic [7:0] SC_AR_ACK = 8'h40;
  localparam logic [7:0] SC_AR_NACK = 8'h48;
  localparam logic [7:0] SC_RD_ACK = 8'h50;
  localparam logic [7:0] SC_RD_NACK = 8'h58;
  localparam logic [7:0] SC_SW_ACK = 8'h60;
  localparam logic [7:0] SC_SW_ARB = 8'h68;
  localparam logic [7:0] SC_SD_ACK = 8'h80;
  localparam logic [7:0] SC_SD_NACK = 8'h88;
  // Master line sequencer states
  typedef enum logic [3:0] {
    G_IDLE = 4'h0,
    G_BUF = 4'h1,
    G_ST_A = 4'h2,
    G_ST_B = 4'h3,
    G_LOW = 4'h4,
    G_HIGH = 4'h5,
    G_HOLD = 4'h6,
    G_RS_A = 4'h7,
    G_RS_B = 4'h8,
    G_SP_A = 4'h9,
    G_SP_B = 4'hA
  } pic_gen_t;
  // Half serial period in system cycles, rounded up
  function automatic logic [11:0] half_period(input logic [2:0] rate);
    int k;
    k = 2 * RATE_KHZ[rate];
    return 12'((SYS_CLK_KHZ + k - 1) / k);
  endfunction
endpackage
